/* File: dv/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
	logic ref_clk = 0;
	logic rst = 1;
	logic [1:0] mode_sel = 0, ovr = 0, act;
	logic fstart = 0, ns_h = 0, ns_v = 0, kill = 0, tape = 0, fmem = 0, s_valid = 0;
	logic [9:0] y_in = 0, c_in = 0, c_out, y_out;
	logic s_ready, o_valid, o_ready, pce, hold = 0, slow = 0, chk_c0 = 0, cap = 0;
	vpm_pkg::vpm_func_t fen;
	logic [19:0] rec[$], outq[$]; // Luma in the upper half, chroma in the lower
	int n_errors = 0, n_tests = 0, cyc = 0;

	always #5 ref_clk = ~ref_clk;

	vpm_mode_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .processing_mode_select(mode_sel),
		.standard_detect_override(ovr), .field_start(fstart), .nonstandard_h(ns_h), .nonstandard_v(ns_v),
		.killer_detect(kill), .tape_playback(tape), .field_memory_present(fmem), .sample_valid(s_valid),
		.luma_converter_input(y_in), .chroma_converter_input(c_in), .sample_ready(s_ready),
		.out_valid(o_valid), .out_ready(o_ready), .luma_out(y_out), .chroma_out(c_out), .active_mode(act),
		.func_enable(fen), .mem_clk_en(), .proc_clk_en(pce));
	vpm_sink_model i_sink (.ref_clk(ref_clk), .rst(rst), .hold_off(hold), .slow(slow), .out_ready(o_ready));

	// Transfers are logged at the falling edge, where ready and valid have settled
	always @(negedge ref_clk) begin
		if (o_valid && o_ready && cap) begin
			outq.push_back({y_out, c_out});
		end
		if (o_valid && o_ready && chk_c0) begin
			`CHK("chroma_out", 10'h000, c_out)
		end
	end
	// Watchdog well above the few thousand cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			tally_and_finish();
		end
	end

	// Enables expected for a mode with quiet killer
	function automatic vpm_pkg::vpm_func_t exp_fn(input logic [1:0] m, input logic ns, fm, tp);
		vpm_pkg::vpm_func_t f;
		f = '0;
		f.three_d_sep = m == 2'h0 && !ns;
		f.line_sep = (m == 2'h0 && ns) || m == 2'h1;
		f.helper_decode = m == 2'h0 && !ns && !tp && fm;
		f.luma_noise_reduction = m[0];
		f.chroma_noise_reduction = m[0];
		f.frame_average_nr = m == 2'h2;
		f.chroma_line_delay = m == 2'h2;
		f.chroma_input_valid = m[1];
		f.line_locked_clock = m == 2'h2;
		return f;
	endfunction

	// Pulse the boundary pin long enough for the synchroniser
	task automatic boundary(input logic [1:0] m);
		@(negedge ref_clk);
		mode_sel = m;
		repeat (5) @(negedge ref_clk);
		fstart = 1;
		repeat (8) @(negedge ref_clk);
		fstart = 0;
		repeat (4) @(negedge ref_clk);
	endtask

	task automatic mode_case(input logic [1:0] m, input logic h, v, tp, fm, input logic [1:0] o);
		logic [8:0] e;
		logic [8:0] mask;
		e = exp_fn(m, h | v, fm, tp);
		mask = (m == 2'h2) ? 9'h1df : 9'h1ff; // Luma nr in frame-average mode is left open
		ns_h = h;
		ns_v = v;
		tape = tp;
		fmem = fm;
		ovr = o;
		boundary(m);
		`CHK("active_mode", m, act)
		`CHK("func_enable", e & mask, fen & mask)
	endtask

	// Drive before a take edge; ready cannot move before that edge, so it decides the take
	task automatic offer(input int n);
		int k;
		k = 0;
		while (k < n) begin
			@(negedge ref_clk);
			if (!pce) begin
				y_in = 10'($urandom);
				c_in = 10'($urandom);
				s_valid = 1;
				if (s_ready) begin
					rec.push_back({y_in, c_in});
					k++;
				end
			end
		end
		@(negedge ref_clk);
		s_valid = 0;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h6eb8));
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 0;
		for (int i = 0; i < 16; i++) begin
			mode_case(i[1:0], 0, 0, i[3], i[2], 2'h0);
		end
		kill = 1;
		boundary(2'h3);
		`CHK("killer nr", 2'h0, {fen.luma_noise_reduction, fen.chroma_noise_reduction})
		kill = 0;
		mode_case(2'h0, 1, 0, 0, 1, 2'h0);
		mode_case(2'h1, 0, 1, 0, 0, 2'h1);
		$display("test modes done");
		// A code written mid-field must wait for the boundary
		mode_sel = 2'h3;
		repeat (30) @(negedge ref_clk);
		`CHK("active_mode held", 2'h1, act)
		boundary(2'h3);
		`CHK("active_mode new", 2'h3, act)
		$display("test boundary done");
		// Stalled consumer: buffer fills and refuses, then drains
		mode_case(2'h1, 0, 0, 0, 0, 2'h0);
		chk_c0 = 1;
		hold = 1;
		s_valid = 1;
		repeat (20) @(negedge ref_clk);
		`CHK("sample_ready full", 1'b0, s_ready)
		`CHK("out_valid full", 1'b1, o_valid)
		s_valid = 0;
		hold = 0;
		slow = 1;
		offer(40);
		repeat (40) @(negedge ref_clk);
		`CHK("out_valid drained", 1'b0, o_valid)
		chk_c0 = 0;
		slow = 0;
		$display("test buffer done");
		// Chroma comes out one line of takes late
		mode_case(2'h2, 0, 0, 0, 0, 2'h0);
		rec.delete();
		outq.delete();
		cap = 1;
		offer(940);
		repeat (20) @(negedge ref_clk);
		cap = 0;
		`CHK("output count", 940, outq.size())
		for (int k = 910; k < 940; k++) begin
			`CHK("chroma_delayed", rec[k - 910][9:0], outq[k][9:0])
			`CHK("luma_out", rec[k][19:10], outq[k][19:10])
		end
		$display("test line delay done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: dv/vpm_mode_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module vpm_mode_checker (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic [1:0] processing_mode_select, // Mode code
	input wire logic [1:0] standard_detect_override, // Override code
	input wire logic field_start, // Boundary pin
	input wire logic nonstandard_h, // Detector
	input wire logic nonstandard_v, // Detector
	input wire logic killer_detect, // Detector
	input wire logic sample_ready, // Room for a sample
	input wire logic [1:0] active_mode, // Mode in force
	input wire vpm_pkg::vpm_func_t func_enable, // Enables
	input wire logic mem_clk_en, // Double-rate phase
	input wire logic proc_clk_en // Single-rate phase
);
	int quiet_cnt;
	int kq_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Cycles since any detector fired; the pin synchronisers hide fresh changes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			quiet_cnt <= 0;
		end else if (nonstandard_h || nonstandard_v || killer_detect) begin
			quiet_cnt <= 0;
		end else if (quiet_cnt < 15) begin
			quiet_cnt <= quiet_cnt + 1;
		end
	end
	// Same for the killer alone, which override cannot mask
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			kq_cnt <= 0;
		end else if (killer_detect) begin
			kq_cnt <= 0;
		end else if (kq_cnt < 15) begin
			kq_cnt <= kq_cnt + 1;
		end
	end
	a_mode_late: assert property ($changed(active_mode) |->
		$past(field_start, 3) || $past(field_start, 4) || $past(field_start, 5)) else $error("mode moved off boundary");
	a_mode_taken: assert property ($rose(field_start) ##1 (field_start && $stable(processing_mode_select)) [*4]
		|-> active_mode == processing_mode_select) else $error("mode not taken at boundary");
	a_chroma_invalid: assert property (!active_mode[1] |-> !func_enable.chroma_input_valid)
		else $error("chroma input valid in composite mode");
	a_fn_exclusive: assert property ($onehot0({func_enable.three_d_sep,
		func_enable.chroma_noise_reduction, func_enable.frame_average_nr})) else $error("functions overlap");
	a_helper_mode: assert property (func_enable.helper_decode |->
		active_mode == 2'h0 && !func_enable.chroma_input_valid) else $error("helper decode outside code 00");
	a_mem_rate: assert property (!$past(rst) |-> mem_clk_en) else $error("memory phase missing");
	a_proc_half: assert property (!$past(rst, 2) |-> proc_clk_en != $past(proc_clk_en))
		else $error("processing phase not half rate");
	a_frame_avg: assert property (active_mode == 2'h2 && quiet_cnt > 8 |-> func_enable.frame_average_nr &&
		func_enable.chroma_line_delay && func_enable.line_locked_clock) else $error("frame average set wrong");
	a_rec_nr: assert property (active_mode == 2'h3 && quiet_cnt > 8 |-> func_enable.luma_noise_reduction &&
		func_enable.chroma_noise_reduction && func_enable.chroma_input_valid) else $error("recursive nr off");
	a_ovr_nr: assert property (active_mode == 2'h1 && standard_detect_override == 2'h1 && kq_cnt > 8
		&& $stable(standard_detect_override)
		|-> func_enable.luma_noise_reduction && func_enable.chroma_noise_reduction) else $error("forced nr off");
	a_sep_std: assert property (active_mode == 2'h0 && quiet_cnt > 8 |->
		func_enable.three_d_sep && !func_enable.line_sep) else $error("3d separation off");
	c_frame_avg: cover property (active_mode == 2'h2);
	c_rec_nr: cover property (active_mode == 2'h3);
	c_full: cover property (!sample_ready);
	c_bound: cover property ($rose(field_start));
endmodule
bind vpm_mode_ctrl vpm_mode_checker i_chk (.ref_clk(ref_clk), .rst(rst),
	.processing_mode_select(processing_mode_select), .standard_detect_override(standard_detect_override),
	.field_start(field_start), .nonstandard_h(nonstandard_h), .nonstandard_v(nonstandard_v),
	.killer_detect(killer_detect), .sample_ready(sample_ready), .active_mode(active_mode),
	.func_enable(func_enable), .mem_clk_en(mem_clk_en), .proc_clk_en(proc_clk_en));
`default_nettype wire

/* File: dv/vpm_sink_model.sv */
`timescale 1ns/100ps
`default_nettype none
module vpm_sink_model (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic hold_off, // Refuse everything
	input wire logic slow, // Accept at random
	output logic out_ready // Accept strobe
);
	// Ready moves just after the edge, so the producer sees it settled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_ready <= 1'b0;
		end else begin
			out_ready <= !hold_off && (!slow || $urandom_range(0, 1) == 1);
		end
	end
endmodule
`default_nettype wire

/* File: hw/vpm_defs.svh */
`ifndef VPM_DEFS_SVH
`define VPM_DEFS_SVH
// Processing mode codes
`define VPM_MODE_3D_SEP 2'h0
`define VPM_MODE_SEP_NR 2'h1
`define VPM_MODE_FRAME_AVG 2'h2
`define VPM_MODE_REC_NR 2'h3
// Standard detection override codes
`define VPM_OVR_AUTO 2'h0
`define VPM_OVR_FORCE_STD 2'h1
// Sample data width
`define VPM_DATA_W 10
// Samples per line at the single-rate clock
`define VPM_LINE_LEN 910
`define VPM_LINE_IDX_W 10
// Buffer depth in words
`define VPM_FIFO_DEPTH 4
// Reset value of the reported mode code
`define VPM_MODE_RST 2'h0
`endif

/* File: hw/vpm_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module vpm_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic in_valid, // Write request
	output logic in_ready, // Room available
	input wire logic [WIDTH-1:0] in_data, // Write word
	output logic out_valid, // Word available
	input wire logic out_ready, // Reader takes word
	output logic [WIDTH-1:0] out_data // Read word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic do_wr;
	logic do_rd;

	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	// Storage written at the write pointer
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (do_wr) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers wrap; depth is a power of two
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// Occupancy
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_reg <= '0;
		end else if (do_wr && !do_rd) begin
			count_reg <= count_reg + 1'b1;
		end else if (do_rd && !do_wr) begin
			count_reg <= count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: hw/vpm_line_delay.sv */
`timescale 1ns/100ps
`default_nettype none
module vpm_line_delay #(
	parameter int WIDTH = 10,
	parameter int LEN = 910,
	parameter int IW = 10
) (
	input wire logic ref_clk, // Clock
	input wire logic rst, // Async reset
	input wire logic advance, // Shift one sample
	input wire logic [WIDTH-1:0] in_data, // Sample in
	output logic [WIDTH-1:0] out_data // Sample one line earlier
);
	// Circular line store; one read-then-write per advance
	logic [WIDTH-1:0] mem_reg [LEN];
	logic [IW-1:0] idx_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idx_reg <= '0;
			out_data <= '0;
			for (int i = 0; i < LEN; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (advance) begin
			out_data <= mem_reg[idx_reg];
			mem_reg[idx_reg] <= in_data;
			idx_reg <= (idx_reg == IW'(LEN - 1)) ? '0 : idx_reg + 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: hw/vpm_mode_ctrl.sv */
// What this block does
// - Code 00 with a standard signal runs motion-adaptive three-dimensional luma/chroma separation.
// - Code 00 with a nonstandard signal falls back to inter-line separation.
// - In code 00 the helper decode is offered only when the extra field memory is fitted.
// - Code 01 runs inter-line separation plus frame-recursive luma and chroma noise reduction.
// - Codes 00 and 01 take composite on the luma converter input and ignore the chroma converter input.
// - Code 10 runs motion-adaptive frame-average luma noise reduction on a line-locked clock.
// - Code 10 delays chroma by one line while luma passes with no line delay.
// - Code 11 runs frame-recursive noise reduction on both separate luma and chroma.
// - Processing runs at the single-rate clock, memory and digital outputs at twice that rate.
// - Three-dimensional separation, recursive and frame-comb noise reduction never run together.
// - No helper decode for separate inputs, tape playback or nonstandard signals not forced standard by override code 01.
// - Override code 01 forces standard treatment so noise reduction keeps running.
`timescale 1ns/100ps
`default_nettype none
`include "vpm_defs.svh"
module vpm_mode_ctrl (
	input wire logic ref_clk, // Double-rate memory and output clock, 100 MHz
	input wire logic rst, // Async reset, active high
	input wire logic [1:0] processing_mode_select, // Mode code from the serial bus
	input wire logic [1:0] standard_detect_override, // Override code from the serial bus
	input wire logic field_start, // Field boundary pin
	input wire logic nonstandard_h, // Horizontal nonstandard detect pin
	input wire logic nonstandard_v, // Vertical nonstandard detect pin
	input wire logic killer_detect, // Colour killer detect pin
	input wire logic tape_playback, // Tape playback detect pin
	input wire logic field_memory_present, // Extra field memory strap
	input wire logic sample_valid, // Sample strobe
	input wire logic [9:0] luma_converter_input, // Luma converter sample
	input wire logic [9:0] chroma_converter_input, // Chroma converter sample
	output logic sample_ready, // Room for a sample
	output logic out_valid, // Output pair valid
	input wire logic out_ready, // Consumer takes pair
	output logic [9:0] luma_out, // Processed luma path sample
	output logic [9:0] chroma_out, // Processed chroma path sample
	output logic [1:0] active_mode, // Mode code now in force
	output vpm_pkg::vpm_func_t func_enable, // Enabled functions
	output logic mem_clk_en, // Double-rate phase for memory and outputs
	output logic proc_clk_en // Single-rate processing phase
);
	// Two-stage synchronisers on pin inputs
	logic [5:0] pin_s1_reg;
	logic [5:0] pin_s2_reg;
	logic field_seen_reg;
	logic field_edge;
	logic fs_sync;
	logic nsh_sync;
	logic nsv_sync;
	logic killer_sync;
	logic tape_sync;
	logic fm_sync;
	vpm_pkg::vpm_mode_t mode_reg;
	vpm_pkg::vpm_mode_t mode_next;
	vpm_pkg::vpm_func_t func_next;
	logic standard;
	logic phase_reg;
	vpm_pkg::vpm_sample_t fifo_in;
	vpm_pkg::vpm_sample_t fifo_out;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [9:0] chroma_delayed;
	logic take;

	// Asynchronous pins pass two flops before use
	// Bit order: boundary, h, v, killer, tape, field memory
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			pin_s1_reg <= {field_memory_present, tape_playback, killer_detect, nonstandard_v, nonstandard_h,
				field_start};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign fs_sync = pin_s2_reg[0];
	assign nsh_sync = pin_s2_reg[1];
	assign nsv_sync = pin_s2_reg[2];
	assign killer_sync = pin_s2_reg[3];
	assign tape_sync = pin_s2_reg[4];
	assign fm_sync = pin_s2_reg[5];

	// Field boundary edge taken from the synchronised level
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			field_seen_reg <= 1'b0;
		end else begin
			field_seen_reg <= fs_sync;
		end
	end

	// Rising edge only; a level held high never retriggers
	assign field_edge = fs_sync && !field_seen_reg;

	// Code to working mode
	// All four codes are legal, so the case needs no default
	function automatic vpm_pkg::vpm_mode_t decode_mode(input logic [1:0] code);
		vpm_pkg::vpm_mode_t m;
		m = vpm_pkg::VPM_SEP_3D;
		unique case (code)
			`VPM_MODE_3D_SEP: m = vpm_pkg::VPM_SEP_3D;
			`VPM_MODE_SEP_NR: m = vpm_pkg::VPM_SEP_NR;
			`VPM_MODE_FRAME_AVG: m = vpm_pkg::VPM_FRAME_AVG;
			`VPM_MODE_REC_NR: m = vpm_pkg::VPM_REC_NR;
		endcase
		return m;
	endfunction

	// Working mode back to its code
	// Reported code follows the working mode, not the bus field
	function automatic logic [1:0] encode_mode(input vpm_pkg::vpm_mode_t m);
		logic [1:0] c;
		c = `VPM_MODE_3D_SEP;
		unique case (m)
			vpm_pkg::VPM_SEP_3D: c = `VPM_MODE_3D_SEP;
			vpm_pkg::VPM_SEP_NR: c = `VPM_MODE_SEP_NR;
			vpm_pkg::VPM_FRAME_AVG: c = `VPM_MODE_FRAME_AVG;
			vpm_pkg::VPM_REC_NR: c = `VPM_MODE_REC_NR;
		endcase
		return c;
	endfunction

	// Recursive NR holds unless vertical nonstandard is seen and not overridden
	function automatic logic nr_allowed(input logic nsv, input logic std);
		logic ok;
		ok = !nsv || std;
		return ok;
	endfunction

	// Mode switches only at a field edge so no frame mixes two modes
	// The code comes from the bus on this clock, so it needs no synchroniser
	always_comb begin
		mode_next = mode_reg;
		if (field_edge) begin
			mode_next = decode_mode(processing_mode_select);
		end
	end

	// Working mode, reset to composite three-dimensional separation
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_reg <= vpm_pkg::VPM_SEP_3D;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Forced standard masks vertical nonstandard detection
	// Either detector marks the input nonstandard; the override masks both
	always_comb begin
		standard = !nsh_sync && !nsv_sync;
		if (standard_detect_override == `VPM_OVR_FORCE_STD) begin
			standard = 1'b1;
		end
	end

	// Exactly one mode's functions enabled; killer stops separation and recursive NR
	// Recursive NR, frame comb and 3D separation sit in different case arms
	always_comb begin
		func_next = '0;
		unique case (mode_reg)
			vpm_pkg::VPM_SEP_3D: begin
				// Killer stops separation; the pair passes straight through
				if (!killer_sync) begin
					func_next.three_d_sep = standard;
					func_next.line_sep = !standard;
				end
				// Helper decode needs the extra field memory and a composite broadcast signal
				func_next.helper_decode = fm_sync && standard && !tape_sync && !killer_sync;
			end
			vpm_pkg::VPM_SEP_NR: begin
				// Vertical nonstandard drops NR but keeps line separation
				if (!killer_sync) begin
					func_next.line_sep = 1'b1;
					func_next.luma_noise_reduction = nr_allowed(nsv_sync, standard);
					func_next.chroma_noise_reduction = nr_allowed(nsv_sync, standard);
				end
			end
			vpm_pkg::VPM_FRAME_AVG: begin
				// Frame comb runs whatever the detectors report
				func_next.frame_average_nr = 1'b1;
				func_next.chroma_line_delay = 1'b1;
				func_next.chroma_input_valid = 1'b1;
				func_next.line_locked_clock = 1'b1;
			end
			vpm_pkg::VPM_REC_NR: begin
				func_next.chroma_input_valid = 1'b1;
				if (!killer_sync && nr_allowed(nsv_sync, standard)) begin
					func_next.luma_noise_reduction = 1'b1;
					func_next.chroma_noise_reduction = 1'b1;
				end
			end
		endcase
	end

	// Registered function enables and mode code
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			func_enable <= '0;
			active_mode <= `VPM_MODE_RST;
		end else begin
			func_enable <= func_next;
			active_mode <= encode_mode(mode_reg);
		end
	end

	// Half-rate phase: memory and outputs see every edge, processing every other
	// One clock serves both rates; the enables mark phases instead of a second clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg <= 1'b0;
			mem_clk_en <= 1'b0;
			proc_clk_en <= 1'b0;
		end else begin
			phase_reg <= !phase_reg;
			mem_clk_en <= 1'b1;
			proc_clk_en <= phase_reg;
		end
	end

	// Samples accepted only on processing phase with room in the buffer
	// Phase gating halves the sample rate to the processing rate
	assign take = sample_valid && sample_ready && phase_reg;

	// One-line chroma delay used in frame-average mode
	// It advances on every take in every mode, so a switch into that mode finds a full line
	vpm_line_delay #(
		.WIDTH(`VPM_DATA_W),
		.LEN(`VPM_LINE_LEN),
		.IW(`VPM_LINE_IDX_W)
	) u_cdelay (
		.ref_clk(ref_clk),
		.rst(rst),
		.advance(take),
		.in_data(chroma_converter_input),
		.out_data(chroma_delayed)
	);

	// Chroma pin ignored in composite modes; delayed chroma lags the read by one clock,
	// matched here by the luma path registered alongside
	always_comb begin
		fifo_in.luma = luma_converter_input;
		fifo_in.chroma = '0;
		if (func_enable.chroma_line_delay) begin
			fifo_in.chroma = chroma_delayed;
		end else if (func_enable.chroma_input_valid) begin
			fifo_in.chroma = chroma_converter_input;
		end
	end

	// Stage between the line store read and the buffer
	vpm_pkg::vpm_sample_t stage_reg;
	logic stage_valid_reg;
	logic fifo_in_ready;

	// Stage register aligns with the line store read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stage_reg <= '0;
			stage_valid_reg <= 1'b0;
		end else begin
			if (take) begin
				stage_reg.luma <= fifo_in.luma;
				// The line store supplies chroma itself when the delay is on
				stage_reg.chroma <= func_enable.chroma_line_delay ? '0 : fifo_in.chroma;
			end
			stage_valid_reg <= take;
		end
	end

	// Delayed chroma joins the staged luma as the word is pushed
	vpm_pkg::vpm_sample_t push_word;

	always_comb begin
		push_word = stage_reg;
		if (func_enable.chroma_line_delay) begin
			push_word.chroma = chroma_delayed;
		end
	end

	// Buffer ahead of the double-rate output stage
	// Four words leave room for the staged word and the one-cycle ready lag
	vpm_fifo #(
		.WIDTH(2 * `VPM_DATA_W),
		.DEPTH(`VPM_FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(stage_valid_reg),
		.in_ready(fifo_in_ready),
		.in_data(push_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// A word leaves the buffer for the output register
	logic pop;
	assign pop = fifo_out_valid && fifo_out_ready;

	// Ready held back two slots early for the staged word in flight and the ready lag
	logic [2:0] fill_reg;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fill_reg <= '0;
		end else if (take && !pop) begin
			fill_reg <= fill_reg + 3'h1;
		end else if (!take && pop) begin
			fill_reg <= fill_reg - 3'h1;
		end
	end

	// Registered ready; the threshold already allows for its one-cycle lag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sample_ready <= 1'b0;
		end else begin
			sample_ready <= (fill_reg < 3'h2) && fifo_in_ready;
		end
	end

	// Registered output stage, one word held until taken
	// It refills in the cycle it empties, so a steady consumer sees no bubbles
	assign fifo_out_ready = !out_valid || out_ready;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			luma_out <= '0;
			chroma_out <= '0;
		end else if (fifo_out_ready) begin
			out_valid <= fifo_out_valid;
			luma_out <= fifo_out.luma;
			chroma_out <= fifo_out.chroma;
		end
	end
endmodule
`default_nettype wire

/* File: hw/vpm_pkg.sv */
package vpm_pkg;
	typedef enum logic [1:0] {
		VPM_SEP_3D = 2'h0,
		VPM_SEP_NR = 2'h1,
		VPM_FRAME_AVG = 2'h3,
		VPM_REC_NR = 2'h2
	} vpm_mode_t;

	// One pair of samples travelling together
	typedef struct packed {
		logic [9:0] luma;
		logic [9:0] chroma;
	} vpm_sample_t;

	// Function enables derived from the working mode
	typedef struct packed {
		logic three_d_sep;
		logic line_sep;
		logic helper_decode;
		logic luma_noise_reduction;
		logic chroma_noise_reduction;
		logic frame_average_nr;
		logic chroma_line_delay;
		logic chroma_input_valid;
		logic line_locked_clock;
	} vpm_func_t;
endpackage
